/* bench/host_model.sv */
`timescale 1ns/1ps
module host_model #(
  parameter int ADDR_W = 30
) (
  // clock
  input  wire logic              core_clk,
  // host side of the port
  input  wire logic              host_ready,
  output logic                   host_select_n,
  output logic                   host_read_strobe_n,
  output logic [ADDR_W-1:0]      host_addr,
  output logic                   host_is_reg
);
  initial begin
    host_select_n = 1'b1;
    host_read_strobe_n = 1'b1;
    host_addr = '0;
    host_is_reg = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one access: select and qualifiers held until ready is sampled high
  task automatic access(input logic rd, input logic rg, input logic [ADDR_W-1:0] a,
                        output int waited);
    waited = 0;
    @(posedge core_clk);
    host_select_n      <= 1'b0;
    host_read_strobe_n <= ~rd;
    host_addr          <= a;
    host_is_reg        <= rg;
    do begin
      @(posedge core_clk);
      waited++;
    end while (host_ready !== 1'b1 && waited < 40);
    // drop select on ready; released lines turn over so stale values never look valid
    host_select_n      <= 1'b1;
    host_read_strobe_n <= rd;
    host_addr          <= ~a;
    host_is_reg        <= ~rg;
  endtask
endmodule // host_model

/* bench/test_host_access_port.sv */
`timescale 1ns/1ps
module test_host_access_port;
  logic core_clk = 1'b0, rst_n = 1'b0, host_ready, host_data_latch_strobe, toe_n, cas_n;
  logic host_select_n, host_read_strobe_n, host_is_reg, buffer_dir_outbound, buffer_dir_inbound;
  logic [1:0] access_mode = 2'h0;
  logic [29:0] host_addr, mem_addr;
  logic seen_out, seen_in, seen_toe, seen_cas, rdy_q;
  logic local_addr_latch_n_n, hoe_n, cas_q, alt_q, hoe_q;
  int n_errors = 0, checked = 0, cyc = 0, t_rdy, t_stb, t_cas_up, t_alt_up, t_hoe_up, w1, w2;
  always #5 core_clk = ~core_clk;
  host_access_port #(.ADDR_W(30)) DUT (.core_clk(core_clk), .rst_n(rst_n),
    .host_select_n(host_select_n), .host_read_strobe_n(host_read_strobe_n),
    .host_addr(host_addr), .host_is_reg(host_is_reg), .access_mode(access_mode),
    .host_ready(host_ready), .host_data_latch_strobe(host_data_latch_strobe),
    .buffer_dir_outbound(buffer_dir_outbound), .buffer_dir_inbound(buffer_dir_inbound),
    .transfer_output_enable_n(toe_n), .column_strobe_n(cas_n), .local_addr_latch_n(local_addr_latch_n_n),
    .host_latch_output_enable_n(hoe_n), .mem_addr(mem_addr));
  host_model #(.ADDR_W(30)) host (.core_clk(core_clk), .host_ready(host_ready),
    .host_select_n(host_select_n), .host_read_strobe_n(host_read_strobe_n),
    .host_addr(host_addr), .host_is_reg(host_is_reg));
  //////////////////////////////////////////////////////////////////////////////
  // watcher: edge stamps and sticky flags, cleared by the scenarios while idle
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    rdy_q <= host_ready;
    if (host_ready === 1'b1 && rdy_q !== 1'b1) t_rdy <= cyc;
    if (host_data_latch_strobe === 1'b1) t_stb <= cyc;
    cas_q <= cas_n;
    alt_q <= local_addr_latch_n_n;
    hoe_q <= hoe_n;
    if (cas_n === 1'b1 && cas_q === 1'b0) t_cas_up <= cyc;
    if (local_addr_latch_n_n === 1'b1 && alt_q === 1'b0) t_alt_up <= cyc;
    if (hoe_n === 1'b1 && hoe_q === 1'b0) t_hoe_up <= cyc;
    if (buffer_dir_outbound === 1'b1) seen_out <= 1'b1;
    if (buffer_dir_inbound === 1'b1) seen_in <= 1'b1;
    if (toe_n === 1'b0) seen_toe <= 1'b1;
    if (cas_n === 1'b0) seen_cas <= 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic clear_idle(input int n);
    repeat (n) @(posedge core_clk);
    {seen_out, seen_in, seen_toe, seen_cas} = 4'h0;
  endtask
  // one host access with a bounded wait for ready
  task automatic go(input logic rd, input logic rg, input logic [29:0] a, output int w);
    host.access(rd, rg, a, w);
    if (w >= 40) begin
      n_errors++;
      results();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic s_mem_read();
    clear_idle(6);
    go(1'b1, 1'b0, 30'h0000100, w1);
    clear_idle(4);
    check(t_stb - t_rdy, 32'h2);
    check(w1 >= 4 && w1 <= 7, 1'b1);
  endtask
  task automatic s_reg_read(input logic [1:0] m);
    access_mode <= m;
    clear_idle(8);
    go(1'b1, 1'b1, 30'h0000004, w1);
    repeat (4) @(posedge core_clk);
    check({seen_toe, seen_cas}, 32'h0);
    check(seen_out, 32'h1);
  endtask
  task automatic s_writes();
    access_mode <= 2'h0;
    clear_idle(8);
    go(1'b0, 1'b0, 30'h0000200, w1);
    go(1'b0, 1'b0, 30'h0000201, w2);
    repeat (4) @(posedge core_clk);
    check(w1 >= 4 && w1 <= 7, 1'b1);
    check(w2, 32'h7);
    check(t_cas_up - t_rdy, 32'h2);
    check(t_alt_up - t_rdy, 32'h2);
    check(t_hoe_up - t_rdy, 32'h2);
    check(seen_in, 32'h1);
    clear_idle(8);
  endtask
  task automatic s_block();
    access_mode <= 2'h1;
    clear_idle(8);
    go(1'b1, 1'b0, 30'h0000300, w1);
    repeat (10) @(posedge core_clk);
    go(1'b1, 1'b0, 30'h0000301, w2);
    check(w2 <= 2, 1'b1);
    check(mem_addr, 32'h0000301);
    repeat (10) @(posedge core_clk);
    go(1'b1, 1'b0, 30'h0000302, w2);
    check(w2 <= 2, 1'b1);
  endtask
  task automatic s_rmw();
    access_mode <= 2'h2;
    clear_idle(8);
    go(1'b0, 1'b0, 30'h0000400, w1);
    clear_idle(4);
    repeat (8) @(posedge core_clk);
    check(seen_cas, 32'h1);
    check(mem_addr, 32'h0000400);
    go(1'b1, 1'b0, 30'h0000400, w2);
    check(w2, 32'h2);
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    s_mem_read();
    for (int m = 0; m < 3; m++) s_reg_read(m[1:0]);
    s_writes();
    s_block();
    s_rmw();
    results();
  end
endmodule // test_host_access_port

/* rtl/host_access_port.sv */
`timescale 1ns/1ps
`include "host_port_cfg.svh"
module host_access_port #(
  parameter int ADDR_W = `ADDR_W
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // host handshake
  input  wire logic              host_select_n,
  input  wire logic              host_read_strobe_n,
  input  wire logic [ADDR_W-1:0] host_addr,
  input  wire logic              host_is_reg,
  input  wire logic [1:0]        access_mode,
  output logic                   host_ready,
  output logic                   host_data_latch_strobe,
  // buffer and memory controls
  output logic                   buffer_dir_outbound,
  output logic                   buffer_dir_inbound,
  output logic                   transfer_output_enable_n,
  output logic                   column_strobe_n,
  output logic                   local_addr_latch_n,
  output logic                   host_latch_output_enable_n,
  output logic [ADDR_W-1:0]      mem_addr
);

  if (ADDR_W < 2 || ADDR_W > 32) begin : g_addr_w_chk
    $error("host_access_port: ADDR_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  host_port_pkg::quarter_t    q_r;
  host_port_pkg::port_state_t st_r;
  logic              req_r;        // request captured at fourth quarter
  logic              req_wr_r;
  logic              req_reg_r;
  logic [ADDR_W-1:0] req_addr_r;
  logic              active_d_r;   // host request seen last cycle
  logic              was_wr_r;
  logic [ADDR_W-1:0] pf_addr_r;
  logic              pf_valid_r;
  logic              pf_pend_r;
  logic              cyc_wr_r;
  logic              cyc_reg_r;
  logic              wr_busy_r;
  logic              host_active;
  logic              host_wr;
  logic              withdraw;
  logic              pf_hit;
  logic              early_q;

  assign host_active = !host_select_n;
  assign host_wr     = host_read_strobe_n;
  // either a change of the read strobe or the select going away ends the request
  assign withdraw    = active_d_r && (host_select_n || host_read_strobe_n != was_wr_r);
  // registered strobes lag a cycle, so driving them from q1/q2 makes them low in q2/q3
  // and already back high when the fourth quarter begins
  assign early_q     = q_r == host_port_pkg::Q1 || q_r == host_port_pkg::Q2;
  assign pf_hit      = host_active && !host_wr && pf_valid_r && (host_addr == pf_addr_r);

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (!rst_n) q_r <= host_port_pkg::Q1;
    else begin
      unique case (q_r)
        host_port_pkg::Q1: q_r <= host_port_pkg::Q2;
        host_port_pkg::Q2: q_r <= host_port_pkg::Q3;
        host_port_pkg::Q3: q_r <= host_port_pkg::Q4;
        host_port_pkg::Q4: q_r <= host_port_pkg::Q1;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      active_d_r <= 1'b0;
      was_wr_r   <= 1'b0;
    end else begin
      active_d_r <= host_active;
      was_wr_r   <= host_wr;
    end
  end

  // sampling only on entry to the fourth quarter; later arrivals wait a full round
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      req_r      <= 1'b0;
      req_wr_r   <= 1'b0;
      req_reg_r  <= 1'b0;
      req_addr_r <= '0;
    end else if (q_r == host_port_pkg::Q3) begin
      req_r      <= host_active && st_r == host_port_pkg::IDLE && !host_ready && !pf_hit;
      req_wr_r   <= host_wr;
      req_reg_r  <= host_is_reg;
      req_addr_r <= host_addr;
    end else if (q_r == host_port_pkg::Q4) begin
      req_r      <= 1'b0;
    end
  end

  // prefetch bookkeeping for block and read-modify-write modes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pf_pend_r  <= 1'b0;
      pf_addr_r  <= '0;
      pf_valid_r <= 1'b0;
    end else if (withdraw && !was_wr_r && access_mode == `MODE_BLOCK) begin
      pf_pend_r  <= 1'b1;
      pf_addr_r  <= mem_addr + ADDR_W'(`ADDR_STEP);
      pf_valid_r <= 1'b0;
    end else if (withdraw && was_wr_r && access_mode == `MODE_RMW) begin
      pf_pend_r  <= 1'b1;
      pf_addr_r  <= mem_addr;
      pf_valid_r <= 1'b0;
    end else if (st_r == host_port_pkg::PF_CYC && q_r == host_port_pkg::Q4) begin
      pf_pend_r  <= 1'b0;
      pf_valid_r <= 1'b1;
    end else if (st_r == host_port_pkg::WR_CYC) begin
      pf_valid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r      <= host_port_pkg::IDLE;
      cyc_wr_r  <= 1'b0;
      cyc_reg_r <= 1'b0;
      mem_addr  <= '0;
    end else if (q_r == host_port_pkg::Q4) begin
      unique case (st_r)
        host_port_pkg::IDLE: begin
          if (req_r) begin
            st_r      <= req_wr_r ? host_port_pkg::WR_CYC : host_port_pkg::RD_CYC;
            cyc_wr_r  <= req_wr_r;
            cyc_reg_r <= req_reg_r;
            mem_addr  <= req_addr_r;
          end else if (pf_pend_r) begin
            st_r      <= host_port_pkg::PF_CYC;
            cyc_wr_r  <= 1'b0;
            cyc_reg_r <= 1'b0;
            mem_addr  <= pf_addr_r;
          end
        end
        host_port_pkg::RD_CYC,
        host_port_pkg::WR_CYC,
        host_port_pkg::PF_CYC: st_r <= host_port_pkg::IDLE;
        host_port_pkg::HOLD:   st_r <= host_port_pkg::IDLE;
      endcase
    end
  end

  // a write is outstanding from its ready until its memory cycle ends at fourth quarter
  always_ff @(posedge core_clk) begin
    if (!rst_n) wr_busy_r <= 1'b0;
    else if (st_r == host_port_pkg::WR_CYC && q_r == host_port_pkg::Q4) wr_busy_r <= 1'b0;
    else if (st_r == host_port_pkg::WR_CYC && q_r == host_port_pkg::Q1) wr_busy_r <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (!rst_n) host_ready <= 1'b0;
    else if (host_select_n) host_ready <= 1'b0;
    else if (pf_hit) host_ready <= 1'b1;
    else if (q_r == host_port_pkg::Q1 && (st_r == host_port_pkg::RD_CYC ||
             (st_r == host_port_pkg::WR_CYC && !wr_busy_r))) host_ready <= 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) host_data_latch_strobe <= 1'b0;
    else host_data_latch_strobe <= q_r == host_port_pkg::Q3 &&
      (st_r == host_port_pkg::RD_CYC || st_r == host_port_pkg::PF_CYC);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      buffer_dir_outbound        <= 1'b0;
      buffer_dir_inbound         <= 1'b0;
      transfer_output_enable_n   <= 1'b1;
      column_strobe_n            <= 1'b1;
      local_addr_latch_n         <= 1'b1;
      host_latch_output_enable_n <= 1'b1;
    end else begin
      buffer_dir_outbound <= (st_r == host_port_pkg::RD_CYC) && cyc_reg_r && q_r != host_port_pkg::Q4;
      buffer_dir_inbound  <= (st_r == host_port_pkg::WR_CYC) && q_r != host_port_pkg::Q4;
      transfer_output_enable_n <= !((st_r == host_port_pkg::RD_CYC || st_r == host_port_pkg::PF_CYC)
                                    && !cyc_reg_r && q_r != host_port_pkg::Q4);
      // memory stays silent for register cycles; strobes return high at fourth quarter
      column_strobe_n <= !(st_r != host_port_pkg::IDLE && st_r != host_port_pkg::HOLD && !cyc_reg_r
                           && early_q);
      local_addr_latch_n <= !(st_r == host_port_pkg::WR_CYC && early_q);
      host_latch_output_enable_n <= !(st_r == host_port_pkg::WR_CYC && early_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_quarter_order: assert property (@(posedge core_clk) disable iff (!rst_n)
    q_r == host_port_pkg::Q4 |=> q_r == host_port_pkg::Q1) else $error("quarter order broken");
  a_cycle_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(st_r != host_port_pkg::IDLE) |-> q_r == host_port_pkg::Q1) else $error("cycle not at Q1");
  a_late_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(req_r) && req_r |-> $past(q_r) == host_port_pkg::Q3) else $error("sample off Q4");
  a_rd_strobe: assert property (@(posedge core_clk) disable iff (!rst_n)
    host_data_latch_strobe |-> $past(st_r) != host_port_pkg::IDLE && q_r == host_port_pkg::Q4)
    else $error("latch strobe off Q4");
  a_reg_silent: assert property (@(posedge core_clk) disable iff (!rst_n)
    buffer_dir_outbound |-> transfer_output_enable_n && column_strobe_n)
    else $error("memory driven on reg read");
  a_reg_outbound: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_r == host_port_pkg::RD_CYC && cyc_reg_r && q_r == host_port_pkg::Q1 |=> buffer_dir_outbound)
    else $error("outbound not enabled");
  a_wr_inbound: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_r == host_port_pkg::WR_CYC && q_r == host_port_pkg::Q1 |=> buffer_dir_inbound [*3])
    else $error("inbound dropped");
  a_wr_end: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_r == host_port_pkg::WR_CYC && q_r == host_port_pkg::Q4 |-> local_addr_latch_n
    && host_latch_output_enable_n && column_strobe_n) else $error("write not ended at Q4");
  a_pf_hit: assert property (@(posedge core_clk) disable iff (!rst_n)
    pf_hit && !host_select_n |=> host_ready || host_select_n) else $error("prefetch hit waited");
  a_rmw_fetch: assert property (@(posedge core_clk) disable iff (!rst_n)
    withdraw && was_wr_r && access_mode == `MODE_RMW |=> pf_pend_r) else $error("rmw no read");

  c_read:   cover property (@(posedge core_clk) disable iff (!rst_n) st_r == host_port_pkg::RD_CYC);
  c_write:  cover property (@(posedge core_clk) disable iff (!rst_n) st_r == host_port_pkg::WR_CYC);
  c_pf:     cover property (@(posedge core_clk) disable iff (!rst_n) pf_hit);
  c_regrd:  cover property (@(posedge core_clk) disable iff (!rst_n) buffer_dir_outbound);

endmodule // host_access_port

/* rtl/host_port_cfg.svh */
// How it works
// - pending host request sampled entering fourth quarter; memory cycle starts next first quarter
// - a request arriving after that sample waits for the next fourth quarter
// - read: ready rises at second quarter, data latch strobe rises at fourth quarter
// - block mode: next sequential read starts when host withdraws current read
// - block mode: each release of read strobe or select after a read launches a new prefetch
// - read with host address equal to prefetched address gives ready at once
// - read-modify-write mode: read of addressed location starts when host write ends
// - register reads suppress transfer/output-enable and column strobes
// - register reads enable outbound buffer direction
// - internal registers reachable in every access mode, except a register read at the prefetched address, which the prefetch answers
// - write with no write pending gets ready at second quarter of its memory cycle, two cycles after it is recognised
// - second write waits for ready until previous memory write finishes
// - inbound buffer direction active during every host write
// - write: ready at second quarter, memory write completes at fourth quarter
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH
`define ADDR_W        30
`define ADDR_STEP     30'h0000001
`define MODE_RANDOM   2'h0
`define MODE_BLOCK    2'h1
`define MODE_RMW      2'h2
`endif

/* rtl/host_port_pkg.sv */
package host_port_pkg;
  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} quarter_t;
  typedef enum logic [2:0] {IDLE, RD_CYC, WR_CYC, PF_CYC, HOLD} port_state_t;
endpackage
